// [rail_sequence_fault_monitor.v]
// Rail sequencer with fault monitor, flash copy and APB register slave.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "rail_seq_map.vh"

// How it works
// RL1 - Rail config needs monitor, enable or margin.
// RL2 - Regulated rails checked against warn/fault limits.
// RL3 - Faults trigger their configured response.
// RL4 - Config in working memory, copied to flash.
// RL5 - Per-rail status flags; faults logged nonvolatile.
// RL6 - On: dependencies met, then delay, enable.
// RL7 - Off: dependencies met, then delay, disable.
// RL8 - Rise and fall times limited, timeout flagged.
// RL9 - Faulted rail also shuts its slave rails.
// RL10 - On command from bus or pin.
// RL11 - Separate good-rise and good-fall levels.
// RL12 - Margin output uses nominal, low, high targets.
// RL13 - Under checks wait for first good level.
module rail_sequence_fault_monitor (
	// Clock and reset.
	input wire ref_clk,
	input wire sys_rst,
	// APB slave.
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Rail side.
	input wire [`RAILS*`LVL_W-1:0] railLevel,
	input wire [`RAILS-1:0] onPin,
	input wire [`GPIS-1:0] gpiIn,
	output reg [`RAILS-1:0] railEn,
	output reg [`RAILS-1:0] railGood,
	output reg [`RAILS*`LVL_W-1:0] marginLevel,
	// Interrupt.
	output reg irq
);

	// ************************************************************
	// States and storage
	// ************************************************************
	localparam [7:0] S_OFF = 8'h01;
	localparam [7:0] S_ONDLY = 8'h02;
	localparam [7:0] S_RISE = 8'h04;
	localparam [7:0] S_REG = 8'h08;
	localparam [7:0] S_OFFWAIT = 8'h10;
	localparam [7:0] S_OFFDLY = 8'h20;
	localparam [7:0] S_FALL = 8'h40;
	localparam integer TICK_N = `TICK_CYC - 1;
	localparam integer IDX_N = `CFG_WORDS - 1;
	localparam [5:0] TICK_LAST = TICK_N[5:0];
	localparam [`IDX_W-1:0] IDX_LAST = IDX_N[`IDX_W-1:0];

	reg [31:0] cfgMem [0:`CFG_WORDS-1];
	reg [31:0] nvMem [0:`CFG_WORDS-1];
	reg [`RAILS-1:0] nvLog_r;
	reg [7:0] st_r [0:`RAILS-1];
	reg [`TMR_W-1:0] tmr_r [0:`RAILS-1];
	reg [`FLAG_W-1:0] flag_r [0:`RAILS-1];
	reg [`RAILS-1:0] en_r;
	reg [`RAILS-1:0] hold_r;
	reg [`RAILS-1:0] reached_r;
	reg [`STAT_W-1:0] stat_r;
	reg [`STAT_W-1:0] mask_r;
	reg [5:0] tickCnt_r;
	reg tick_r;
	reg storeBusy_r;
	reg recallBusy_r;
	reg [`IDX_W-1:0] nvIdx_r;
	reg storeDone;

	// Per-rail decoded conditions.
	reg [31:0] cw;
	reg [31:0] tw;
	reg [31:0] gw;
	reg [31:0] uw;
	reg [31:0] ow;
	reg [31:0] dw;
	reg [31:0] nw;
	reg [31:0] mw;
	reg [`LVL_W-1:0] lv;
	reg [`RAILS-1:0] onCmd, onOk, offOk, onDone, offDone, riseHit, fallHit;
	reg [`RAILS-1:0] ovF, uvF, ovW, uvW, tonTo, toffTo, fEv, rspHold, rspSeq;
	reg [`RAILS-1:0] slaveHit, slaveHold, monP, enP;
	reg [`RAILS*`LVL_W-1:0] mgn;
	reg [31:0] rdMux;
	reg mapped;
	reg badCfg;

	wire wEn = psel & penable & pready & pwrite & ~pslverr;
	wire wCfg = wEn & ~paddr[7];
	wire wStat = wEn & (paddr == `A_STATUS);
	wire wMask = wEn & (paddr == `A_MASK);
	wire wCtrl = wEn & (paddr == `A_CTRL);
	wire wRstat = wEn & (paddr[7:4] == `A_RSTAT);

	// ************************************************************
	// Per-rail combinational checks
	// ************************************************************
	// Faults are only judged in states where they mean something, so a rail
	// that is ramping never trips its under limit by accident.
	always @* begin : railChecks
		integer i;
		integer j;
		i = 0;
		j = 0;
		cw = 32'h0; tw = 32'h0; gw = 32'h0; uw = 32'h0; ow = 32'h0;
		dw = 32'h0; nw = 32'h0; mw = 32'h0; lv = {`LVL_W{1'b0}};
		onCmd = 0; onOk = 0; offOk = 0; onDone = 0; offDone = 0;
		riseHit = 0; fallHit = 0; ovF = 0; uvF = 0; ovW = 0; uvW = 0;
		tonTo = 0; toffTo = 0; fEv = 0; rspHold = 0; rspSeq = 0;
		slaveHit = 0; slaveHold = 0; monP = 0; enP = 0;
		mgn = {`RAILS*`LVL_W{1'b0}};
		for (i = 0; i < `RAILS; i = i + 1) begin
			cw = cfgMem[i*`WPR+`W_CFG];
			dw = cfgMem[i*`WPR+`W_DLY];
			tw = cfgMem[i*`WPR+`W_TMAX];
			gw = cfgMem[i*`WPR+`W_GOOD];
			uw = cfgMem[i*`WPR+`W_UV];
			ow = cfgMem[i*`WPR+`W_OV];
			nw = cfgMem[i*`WPR+`W_NOM];
			mw = cfgMem[i*`WPR+`W_MLH];
			lv = railLevel[i*`LVL_W +: `LVL_W];
			monP[i] = cw[`F_MON];
			enP[i] = cw[`F_EN];
			onCmd[i] = cw[`F_PIN] ? onPin[i] : cw[`F_BUSON]; // [RL10]
			onOk[i] = ((cw[`F_ONDEP] & railGood) == cw[`F_ONDEP]) &&
				((cw[`F_ONGPI] & gpiIn) == cw[`F_ONGPI]); // [RL6]
			offOk[i] = ((cw[`F_OFFDEP] & railGood) == {`RAILS{1'b0}}) &&
				((cw[`F_OFFGPI] & gpiIn) == cw[`F_OFFGPI]); // [RL7]
			onDone[i] = tick_r && (tmr_r[i] >= dw[`F_TLO]); // [RL6]
			offDone[i] = tick_r && (tmr_r[i] >= dw[`F_THI]); // [RL7]
			riseHit[i] = lv >= gw[`F_LO]; // [RL11]
			fallHit[i] = lv < gw[`F_HI]; // [RL11]
			ovF[i] = (st_r[i] == S_REG) && (lv > ow[`F_HI]); // [RL2]
			ovW[i] = (st_r[i] == S_REG) && (lv > ow[`F_LO]); // [RL2]
			uvF[i] = (st_r[i] == S_REG) && reached_r[i] && (lv < uw[`F_HI]); // [RL13]
			uvW[i] = (st_r[i] == S_REG) && reached_r[i] && (lv < uw[`F_LO]); // [RL13]
			tonTo[i] = (st_r[i] == S_RISE) && !railGood[i] && tick_r &&
				(tmr_r[i] >= tw[`F_TLO]); // [RL8]
			toffTo[i] = (st_r[i] == S_FALL) && railGood[i] && tick_r &&
				(tmr_r[i] >= tw[`F_THI]); // [RL8]
			fEv[i] = ovF[i] | uvF[i] | tonTo[i];
			rspHold[i] = (cw[`F_RSP] == `RSP_SHUT) || (cw[`F_RSP] == `RSP_SEQOFF); // [RL3]
			rspSeq[i] = cw[`F_RSP] == `RSP_SEQOFF; // [RL3]
			if (cw[`F_MRG]) begin
				case (nw[`F_MMODE])
					`MM_LOW: mgn[i*`LVL_W +: `LVL_W] = mw[`F_LO]; // [RL12]
					`MM_HIGH: mgn[i*`LVL_W +: `LVL_W] = mw[`F_HI]; // [RL12]
					default: mgn[i*`LVL_W +: `LVL_W] = nw[`F_LO]; // [RL12]
				endcase
			end
		end
		// A slave released by a group or restart master sequences back on.
		for (j = 0; j < `RAILS; j = j + 1) begin
			cw = cfgMem[j*`WPR+`W_CFG];
			for (i = 0; i < `RAILS; i = i + 1) begin
				if (fEv[j] && cw[`F_SLV_LSB + i] && (i != j)) begin
					slaveHit[i] = 1'b1; // [RL9]
					slaveHold[i] = slaveHold[i] | rspHold[j];
				end
			end
		end
	end

	// ************************************************************
	// Microsecond tick
	// ************************************************************
	// One shared prescaler keeps every rail's timers on the same grid.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			tickCnt_r <= 6'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tickCnt_r == TICK_LAST);
			tickCnt_r <= (tickCnt_r == TICK_LAST) ? 6'h00 : tickCnt_r + 6'h01;
		end
	end

	// ************************************************************
	// Rail sequencers
	// ************************************************************
	// Fault handling is written last so that it overrides sequencing.
	always @(posedge ref_clk) begin : railSeq
		integer i;
		if (sys_rst) begin
			for (i = 0; i < `RAILS; i = i + 1) begin
				st_r[i] <= S_OFF;
				tmr_r[i] <= {`TMR_W{1'b0}};
				flag_r[i] <= {`FLAG_W{1'b0}};
			end
			en_r <= 0;
			hold_r <= 0;
			reached_r <= 0;
			railEn <= 0;
			railGood <= 0;
			marginLevel <= 0;
		end else begin
			railEn <= en_r & enP;
			marginLevel <= mgn;
			for (i = 0; i < `RAILS; i = i + 1) begin
				// Without a monitor the rail counts as good while enabled.
				if (monP[i])
					railGood[i] <= railGood[i] ? !fallHit[i] : riseHit[i]; // [RL11]
				else
					railGood[i] <= en_r[i];
				if (tick_r && !(&tmr_r[i]))
					tmr_r[i] <= tmr_r[i] + 1'b1;
				if (!onCmd[i])
					hold_r[i] <= 1'b0;
				case (st_r[i])
					S_OFF: begin
						if (onCmd[i] && !hold_r[i] && onOk[i]) begin // [RL6]
							st_r[i] <= S_ONDLY;
							tmr_r[i] <= {`TMR_W{1'b0}};
						end
					end
					S_ONDLY: begin
						if (!onCmd[i]) begin
							st_r[i] <= S_OFF;
						end else if (onDone[i]) begin // [RL6]
							st_r[i] <= S_RISE;
							en_r[i] <= 1'b1;
							reached_r[i] <= 1'b0;
							tmr_r[i] <= {`TMR_W{1'b0}};
						end
					end
					S_RISE: begin
						if (!onCmd[i]) begin
							st_r[i] <= S_OFFWAIT;
						end else if (railGood[i]) begin
							st_r[i] <= S_REG;
							reached_r[i] <= 1'b1; // [RL13]
						end
					end
					S_REG: begin
						if (!onCmd[i])
							st_r[i] <= S_OFFWAIT;
					end
					S_OFFWAIT: begin
						if (offOk[i]) begin // [RL7]
							st_r[i] <= S_OFFDLY;
							tmr_r[i] <= {`TMR_W{1'b0}};
						end
					end
					S_OFFDLY: begin
						if (offDone[i]) begin // [RL7]
							st_r[i] <= S_FALL;
							en_r[i] <= 1'b0;
							tmr_r[i] <= {`TMR_W{1'b0}};
						end
					end
					S_FALL: begin
						if (!railGood[i] || toffTo[i])
							st_r[i] <= S_OFF; // [RL8]
					end
					default: st_r[i] <= S_OFF;
				endcase
				if (fEv[i]) begin
					hold_r[i] <= rspHold[i]; // [RL3]
					tmr_r[i] <= {`TMR_W{1'b0}};
					if (rspSeq[i]) begin
						st_r[i] <= S_OFFDLY; // [RL3]
					end else begin
						st_r[i] <= S_OFF; // [RL3]
						en_r[i] <= 1'b0;
					end
				end else if (slaveHit[i] && st_r[i] != S_OFF) begin
					st_r[i] <= S_OFF; // [RL9]
					en_r[i] <= 1'b0;
					hold_r[i] <= slaveHold[i];
				end
				// Sticky per-rail flags; a new event beats a clear.
				flag_r[i] <= (flag_r[i] & ~((wRstat && paddr[3:2] == i) ?
					pwdata[`FLAG_W-1:0] : {`FLAG_W{1'b0}})) |
					{slaveHit[i] & st_r[i] != S_OFF, uvW[i], ovW[i],
					toffTo[i], tonTo[i], uvF[i], ovF[i]}; // [RL5]
			end
		end
	end

	// ************************************************************
	// Working memory and flash copy
	// ************************************************************
	// Bus writes beat a recall of the same word; a store walks one word
	// a cycle, so words written during a store may land either way.
	always @(posedge ref_clk) begin : cfgStore
		integer i;
		if (sys_rst) begin
			for (i = 0; i < `CFG_WORDS; i = i + 1)
				cfgMem[i] <= 32'h0;
		end else begin
			if (recallBusy_r)
				cfgMem[nvIdx_r] <= nvMem[nvIdx_r]; // [RL4]
			if (wCfg)
				cfgMem[paddr[6:2]] <= pwdata; // [RL4]
		end
	end

	// Flash contents and the fault log have no reset: they must survive it.
	always @(posedge ref_clk) begin
		if (storeBusy_r)
			nvMem[nvIdx_r] <= cfgMem[nvIdx_r]; // [RL4]
		// A fault in the clearing cycle still lands in the log.
		if (wCtrl && pwdata[`C_LOGCLR])
			nvLog_r <= fEv;
		else
			nvLog_r <= nvLog_r | fEv; // [RL5]
	end

	// Store and recall walker.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			storeBusy_r <= 1'b0;
			recallBusy_r <= 1'b0;
			nvIdx_r <= {`IDX_W{1'b0}};
			storeDone <= 1'b0;
		end else begin
			storeDone <= storeBusy_r && (nvIdx_r == IDX_LAST);
			if (storeBusy_r || recallBusy_r) begin
				nvIdx_r <= nvIdx_r + 1'b1;
				if (nvIdx_r == IDX_LAST) begin
					storeBusy_r <= 1'b0;
					recallBusy_r <= 1'b0;
				end
			end else if (wCtrl && pwdata[`C_STORE]) begin
				storeBusy_r <= 1'b1; // [RL4]
			end else if (wCtrl && pwdata[`C_RECALL]) begin
				recallBusy_r <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Interrupts and APB slave
	// ************************************************************
	// Set wins over a write-one clear, so no event is lost.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			stat_r <= {`STAT_W{1'b0}};
			mask_r <= {`STAT_W{1'b0}};
			irq <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~(wStat ? pwdata[`STAT_W-1:0] : {`STAT_W{1'b0}})) |
				{storeDone, ovW | uvW, fEv | toffTo | slaveHit};
			if (wMask)
				mask_r <= pwdata[`STAT_W-1:0];
			irq <= |(stat_r & mask_r);
		end
	end

	// Read mux and decode, evaluated during the setup cycle.
	always @* begin
		rdMux = 32'h0;
		mapped = 1'b1;
		if (!paddr[7])
			rdMux = cfgMem[paddr[6:2]];
		else if (paddr == `A_STATUS)
			rdMux[`STAT_W-1:0] = stat_r;
		else if (paddr == `A_MASK)
			rdMux[`STAT_W-1:0] = mask_r;
		else if (paddr == `A_CTRL)
			rdMux[1:0] = {recallBusy_r, storeBusy_r};
		else if (paddr == `A_LOG)
			rdMux[`RAILS-1:0] = nvLog_r;
		else if (paddr[7:4] == `A_RSTAT)
			rdMux = {st_r[paddr[3:2]], 6'h00, en_r[paddr[3:2]],
				railGood[paddr[3:2]], 9'h000, flag_r[paddr[3:2]]};
		else
			mapped = 1'b0;
		// A rail with no monitor, enable or margin is not accepted.
		badCfg = pwrite && !paddr[7] && (paddr[4:2] == `W_CFG) &&
			(pwdata[`F_ELEM] == 3'h0); // [RL1]
	end

	// No wait state: pready rises in the first access cycle.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0 : rdMux;
				pslverr <= ~mapped | badCfg; // [RL1]
			end
		end
	end

endmodule // rail_sequence_fault_monitor

// [rail_seq_map.vh]
// Register map, field positions and timing constants of the rail sequencer.
`ifndef RAIL_SEQ_MAP_VH
`define RAIL_SEQ_MAP_VH

// Sizes.
`define RAILS 4
`define GPIS 4
`define LVL_W 12
`define CFG_WORDS 32
`define IDX_W 5
`define WPR 8
`define TMR_W 16
`define FLAG_W 7
`define STAT_W 9

// Word index of each per-rail configuration word inside a rail's block of eight.
`define W_CFG 0
`define W_DLY 1
`define W_TMAX 2
`define W_GOOD 3
`define W_UV 4
`define W_OV 5
`define W_NOM 6
`define W_MLH 7

// Global register byte addresses; rail config sits at 8'h00 to 8'h7C.
`define A_STATUS 8'h80
`define A_MASK 8'h84
`define A_CTRL 8'h88
`define A_LOG 8'h8C
`define A_RSTAT 4'hA

// Rail config word fields.
`define F_ELEM 2:0
`define F_MON 0
`define F_EN 1
`define F_MRG 2
`define F_PIN 3
`define F_BUSON 4
`define F_RSP 6:5
`define F_ONDEP 11:8
`define F_OFFDEP 15:12
`define F_SLV 19:16
`define F_SLV_LSB 16
`define F_ONGPI 23:20
`define F_OFFGPI 27:24
// Two 12-bit levels per word, and two 16-bit times per word.
`define F_LO 11:0
`define F_HI 27:16
`define F_TLO 15:0
`define F_THI 31:16
`define F_MMODE 13:12

// Fault responses and margin modes.
`define RSP_RESTART 2'h0
`define RSP_SHUT 2'h1
`define RSP_SEQOFF 2'h2
`define RSP_GROUP 2'h3
`define MM_LOW 2'h1
`define MM_HIGH 2'h2

// Control bits and status layout.
`define C_STORE 0
`define C_RECALL 1
`define C_LOGCLR 2
`define I_WARN_LO 4
`define I_STORE 8

// Rail flag bits.
`define RF_OVF 0
`define RF_UVF 1
`define RF_TON 2
`define RF_TOFF 3
`define RF_OVW 4
`define RF_UVW 5
`define RF_SLV 6

// Timing: delays and limits count in microsecond ticks.
`define US_NS 1000
`define CLK_NS 25
`define TICK_CYC ((`US_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [rail_supply_model.sv]
// Behavioural model of four supply rails that ramp toward a set level.
`timescale 1ns/1ps
module rail_supply_model (
	// Clock.
	input wire ref_clk,
	// Enables from the sequencer and levels chosen by the bench.
	input wire [3:0] railEn,
	input wire [47:0] target,
	// Sensed rail voltages.
	output reg [47:0] railLevel
);
	// ****
	// Ramp
	// ****
	integer i;
	reg [11:0] lvl;
	reg [11:0] goal;
	initial railLevel = 48'h0;
	// A rail slews 16 codes a clock, so it is never good at once after enable.
	always @(posedge ref_clk) begin
		for (i = 0; i < 4; i = i + 1) begin
			lvl = railLevel[12*i +: 12];
			goal = railEn[i] ? target[12*i +: 12] : 12'h000;
			if (lvl < goal) begin
				lvl = (goal - lvl > 12'h010) ? lvl + 12'h010 : goal;
			end else if (lvl > goal) begin
				lvl = (lvl - goal > 12'h010) ? lvl - 12'h010 : goal;
			end
			railLevel[12*i +: 12] <= lvl;
		end
	end
endmodule // rail_supply_model

// [rail_seq_properties.sv]
// Port-level assertions for the rail sequencer.
`timescale 1ns/1ps
module rail_seq_properties (
	// Clock and reset.
	input wire ref_clk,
	input wire sys_rst,
	// APB.
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Rails and interrupt.
	input wire [3:0] railEn,
	input wire irq
);
	// ****
	// Properties
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Decoded request kinds.
	wire setup = psel && !penable;
	wire unmapped = paddr[7:4] == 4'h9 || paddr[7:4] > 4'hA;
	wire badCfg = pwrite && !paddr[7] && paddr[4:2] == 3'h0 && pwdata[2:0] == 3'h0;
	AST_READY_AFTER_SETUP: assert property (setup |=> pready)
		else $error("pready missing after setup");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_NO_READY_IDLE: assert property (!psel |=> !pready)
		else $error("pready without select");
	AST_UNMAPPED_ERR: assert property (setup && unmapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_CFG_REJECT: assert property (setup && badCfg |=> pslverr)
		else $error("empty rail definition accepted");
	AST_RDATA_HOLD: assert property (!setup |=> $stable(prdata) && $stable(pslverr))
		else $error("read data moved outside setup");
	AST_RESET_QUIET: assert property ($fell(sys_rst) |-> railEn == 4'h0 && !irq && !pready)
		else $error("outputs active after reset");
	// Status only clears by a write, so the interrupt may only drop after one.
	AST_IRQ_FALL_BY_WRITE: assert property ($fell(irq) && !$past(sys_rst)
		|-> $past(psel && penable && pwrite, 2))
		else $error("interrupt dropped without a write");
	COV_REFUSED: cover property (pready && pslverr);
	COV_IRQ: cover property ($rose(irq));
	COV_ENABLE: cover property ($rose(railEn[0]));
endmodule // rail_seq_properties
bind rail_sequence_fault_monitor rail_seq_properties props (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.railEn(railEn), .irq(irq));

// [rail_sequence_fault_monitor_test.sv]
// Self-checking bench for the rail sequencer.
`timescale 1ns/1ps
module rail_sequence_fault_monitor_test;
	// ****
	// Signals
	// ****
	reg ref_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] paddr = 8'h0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] onPin = 4'h0;
	reg [3:0] gpiIn = 4'h0;
	reg [47:0] target = 48'h500;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [47:0] railLevel, marginLevel;
	wire [3:0] railEn, railGood;
	wire [7:0] obs = {railGood, railEn};
	reg [31:0] rd;
	reg er;
	integer cyc, k;
	integer errCount = 0;
	integer testsRun = 0;
	// Rail 0: shutdown response, slave rail 1, on delay 2 us, low margin.
	reg [31:0] cfg0 [0:7] = '{32'h20037, 32'h2, 32'h640064, 32'h3000400,
		32'h3000380, 32'h7000600, 32'h1500, 32'h5800480};
	always #12.5 ref_clk = ~ref_clk;
	rail_sequence_fault_monitor uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .railLevel(railLevel), .onPin(onPin),
		.gpiIn(gpiIn), .railEn(railEn), .railGood(railGood), .marginLevel(marginLevel),
		.irq(irq));
	rail_supply_model rails (.ref_clk(ref_clk), .railEn(railEn), .target(target),
		.railLevel(railLevel));
	// ****
	// Tasks
	// ****
	task printVerdict;
		begin
			$display("Checks %0d, errors %0d", testsRun, errCount);
			if (errCount == 0 && testsRun > 0) begin
				$display("TEST PASSED");
			end else begin
				$display("TEST FAILED");
			end
			$finish;
		end
	endtask
	task cmp(input string nm, input [31:0] e, input [31:0] g);
		begin
			testsRun = testsRun + 1;
			if (g !== e) begin
				errCount = errCount + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// One APB transfer; the request holds until pready is seen at an edge.
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'b1;
			@(posedge ref_clk);
			while (pready !== 1'b1) begin
				@(posedge ref_clk);
			end
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			apb(1'b0, a, 32'h0);
			cmp("register", e, rd & m);
		end
	endtask
	// Waits a bounded time for one rail output to reach a level.
	task waitBit(input integer i, input v);
		begin
			cyc = 0;
			while (obs[i] !== v && cyc < 600) begin
				@(posedge ref_clk);
				cyc = cyc + 1;
			end
			cmp("rail output", {31'h0, v}, {31'h0, obs[i]});
		end
	endtask
	// ****
	// Tests
	// ****
	initial begin
		#(25 * 10000);
		errCount = errCount + 1;
		printVerdict;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rdc(8'h80, 32'h1FF, 32'h0);
		rdc(8'h88, 32'h3, 32'h0);
		apb(1'b0, 8'h90, 32'h0);
		cmp("unmapped error", 32'h1, {31'h0, er});
		apb(1'b1, 8'h20, 32'h10);
		cmp("empty rail error", 32'h1, {31'h0, er});
		rdc(8'h20, 32'hFFFFFFFF, 32'h0);
		wr(8'h84, 32'h1);
		wr(8'h20, 32'h12);
		for (k = 1; k < 8; k = k + 1) begin
			wr(8'h4 * k, cfg0[k]);
		end
		wr(8'h0, cfg0[0]);
		waitBit(0, 1'b1);
		cmp("on delay", 32'h1, {31'h0, cyc >= 80});
		waitBit(4, 1'b1);
		rdc(8'hA0, 32'h3007F, 32'h30000);
		cmp("margin low", 32'h480, {20'h0, marginLevel[11:0]});
		wr(8'h18, 32'h2500);
		repeat (2) @(posedge ref_clk);
		cmp("margin high", 32'h580, {20'h0, marginLevel[11:0]});
		wr(8'h18, 32'h500);
		repeat (2) @(posedge ref_clk);
		cmp("margin nominal", 32'h500, {20'h0, marginLevel[11:0]});
		// Dip under the warning level but stay above the fault and good-fall levels.
		target[11:0] <= 12'h370;
		repeat (40) @(posedge ref_clk);
		rdc(8'hA0, 32'h22, 32'h20);
		target[11:0] <= 12'h650;
		repeat (60) @(posedge ref_clk);
		rdc(8'hA0, 32'h20011, 32'h20010);
		cmp("irq masked", 32'h0, {31'h0, irq});
		target[11:0] <= 12'h750;
		waitBit(0, 1'b0);
		rdc(8'hA0, 32'h1, 32'h1);
		waitBit(1, 1'b0);
		rdc(8'hA4, 32'h40, 32'h40);
		cmp("irq set", 32'h1, {31'h0, irq});
		wr(8'h80, 32'h1);
		repeat (2) @(posedge ref_clk);
		cmp("irq clear", 32'h0, {31'h0, irq});
		rdc(8'h8C, 32'h1, 32'h1);
		target[35:24] <= 12'h000;
		wr(8'h48, 32'h2);
		wr(8'h4C, 32'h3000400);
		wr(8'h40, 32'h33);
		waitBit(2, 1'b1);
		waitBit(2, 1'b0);
		cmp("rise limit", 32'h1, {31'h0, cyc >= 80});
		rdc(8'hA8, 32'h4, 32'h4);
		// Sequence-off response: the rail stays on through its 2 us off delay.
		wr(8'h44, 32'h20000);
		wr(8'h40, 32'h43);
		wr(8'h40, 32'h53);
		waitBit(2, 1'b1);
		waitBit(2, 1'b0);
		cmp("sequence off", 32'h1, {31'h0, cyc >= 160});
		wr(8'h60, 32'h100000A);
		repeat (2) @(posedge ref_clk);
		cmp("pin off", 32'h0, {31'h0, railEn[3]});
		onPin[3] <= 1'b1;
		waitBit(3, 1'b1);
		onPin[3] <= 1'b0;
		repeat (100) @(posedge ref_clk);
		cmp("off wait", 32'h1, {31'h0, railEn[3]});
		gpiIn[0] <= 1'b1;
		waitBit(3, 1'b0);
		wr(8'h88, 32'h1);
		repeat (40) @(posedge ref_clk);
		rdc(8'h80, 32'h100, 32'h100);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rdc(8'h4, 32'hFFFFFFFF, 32'h0);
		wr(8'h88, 32'h2);
		repeat (40) @(posedge ref_clk);
		rdc(8'h4, 32'hFFFFFFFF, 32'h2);
		printVerdict;
	end
endmodule // rail_sequence_fault_monitor_test
